/* hw/aar_ctrl.sv */
/*
 * Region and mode control for automatic exposure and automatic white
 * balance, with an APB register port, exposure metering and ratio stepping.
 * Assumes a single clock, synchronous active-low reset and a pixel stream
 * and white balance estimator on that clock.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// Overview of operation
// [R01] Selector picks exposure or balance region
// [R02] Enable picks user region over default
// [R03] Separate left position per algorithm
// [R04] Separate top position per algorithm
// [R05] Separate width and height per algorithm
// [R06] Balance profile is host read/write
// [R07] Ratios never below lower limit; code clamps a ratio only when wb_update steps it
// [R08] Ratios never above upper limit; code clamps only on wb_update, and the lower limit wins if the limits cross
// [R09] More damping gives smaller ratio steps
// [R10] Target mode: automatic or user value
// [R11] Compare target against linear pixel statistics
// [R12] User mode uses host target grey
// [R13] Lighting modes back, front, normal; normal reset
// [R14] Metering applies only under normal lighting
// [R15] Metering: average, spot, partial
// [R16] Average weighs all pixels equally
// [R17] Spot measures centred ~3% area
// [R18] Partial measures centred ~11% area
// [R19] Profiles indoor free, outdoor daylight band
// [R20] Host keeps regions within image
// [R21] Disabled region means whole image
`timescale 1ns/1ps
`default_nettype none
module aar_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Linear pixel stream
	input wire logic pix_valid,
	input wire logic [15:0] pix_x,
	input wire logic [15:0] pix_y,
	input wire logic [7:0] pix_value,
	input wire logic frame_end,
	// White balance estimator
	input wire logic wb_update,
	input wire logic [11:0] wb_proposed_red,
	input wire logic [11:0] wb_proposed_blue,
	// Exposure verdict
	output logic ae_too_bright,
	output logic ae_too_dark,
	output logic ae_valid,
	// White balance results
	output logic [11:0] red_ratio,
	output logic [11:0] blue_ratio,
	output logic [15:0] awb_left,
	output logic [15:0] awb_top,
	output logic [15:0] awb_width,
	output logic [15:0] awb_height
);
	import aar_pkg::*;

	// Settings
	aar_algo_t algorithm_choice;
	logic wb_outdoor;
	logic target_user;
	aar_light_t lighting;
	aar_meter_t metering;
	logic region_use_enable [2];
	logic [15:0] region_left_position [2];
	logic [15:0] region_top_position [2];
	logic [15:0] region_width [2];
	logic [15:0] region_height [2];
	logic [15:0] img_width;
	logic [15:0] img_height;
	logic [11:0] wb_lower;
	logic [11:0] wb_upper;
	logic [3:0] wb_damping;
	logic [7:0] target_grey;
	logic [11:0] colour_gain_ratio [2];
	logic meter_live; // Centre metering in force
	logic [7:0] target_used; // Grey level the verdict aims at

	aar_win_if win ();

	// Bus phase decode
	wire access = psel & penable;
	wire wr_fire = access & pready & pwrite;
	wire sel_ctrl = paddr == AAR_OFF_CTRL;
	wire sel_en = paddr == AAR_OFF_REG_EN;
	wire sel_left = paddr == AAR_OFF_REG_LEFT;
	wire sel_top = paddr == AAR_OFF_REG_TOP;
	wire sel_width = paddr == AAR_OFF_REG_WIDTH;
	wire sel_height = paddr == AAR_OFF_REG_HEIGHT;
	wire sel_img = paddr == AAR_OFF_IMG_SIZE;
	wire sel_lower = paddr == AAR_OFF_WB_LOWER;
	wire sel_upper = paddr == AAR_OFF_WB_UPPER;
	wire sel_damp = paddr == AAR_OFF_WB_DAMP;
	wire sel_target = paddr == AAR_OFF_TARGET;
	wire sel_status = paddr == AAR_OFF_STATUS;
	wire sel_red = paddr == AAR_OFF_RED;
	wire sel_blue = paddr == AAR_OFF_BLUE;
	wire addr_hit = sel_ctrl | sel_en | sel_left | sel_top | sel_width | sel_height |
		sel_img | sel_lower | sel_upper | sel_damp | sel_target | sel_status |
		sel_red | sel_blue;
	// Read-only registers refuse writes
	wire bad_write = pwrite & (sel_status | sel_red | sel_blue);

	// Control write fields
	wire [1:0] wr_light = pwdata[AAR_CTRL_LIGHT +: 2];
	wire [1:0] wr_meter = pwdata[AAR_CTRL_METER +: 2];
	wire light_ok = wr_light != 2'h3;
	wire meter_ok = wr_meter != 2'h3;
	wire sel_idx = algorithm_choice;

	// Read mux
	wire [31:0] ctrl_word = {24'h0, metering, lighting, 1'b0, target_user, wb_outdoor,
		algorithm_choice};
	wire [31:0] status_word = {16'h0, target_used, 5'h0, meter_live, ae_too_dark,
		ae_too_bright};
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_word :
		sel_en ? {31'h0, region_use_enable[sel_idx]} :
		sel_left ? {16'h0, region_left_position[sel_idx]} :
		sel_top ? {16'h0, region_top_position[sel_idx]} :
		sel_width ? {16'h0, region_width[sel_idx]} :
		sel_height ? {16'h0, region_height[sel_idx]} :
		sel_img ? {img_height, img_width} :
		sel_lower ? {20'h0, wb_lower} :
		sel_upper ? {20'h0, wb_upper} :
		sel_damp ? {28'h0, wb_damping} :
		sel_target ? {24'h0, target_grey} :
		sel_status ? status_word :
		sel_red ? {20'h0, colour_gain_ratio[0]} :
		sel_blue ? {20'h0, colour_gain_ratio[1]} : 32'h0;

	// APB answer one cycle into the access phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & (~addr_hit | bad_write);
			prdata <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// [R01] Selector write
	// [R06] Profile write
	// [R13] Lighting defaults to normal
	always_ff @(posedge clk) begin
		if (!rstn) begin
			algorithm_choice <= AAR_ALGO_AE;
			wb_outdoor <= 1'b0;
			target_user <= 1'b0;
			lighting <= AAR_LIGHT_NORMAL;
			metering <= AAR_METER_AVG;
		end else if (wr_fire && sel_ctrl) begin
			algorithm_choice <= aar_algo_t'(pwdata[AAR_CTRL_ALGO]);
			wb_outdoor <= pwdata[AAR_CTRL_PROFILE];
			target_user <= pwdata[AAR_CTRL_TMODE];
			if (light_ok) begin
				lighting <= aar_light_t'(wr_light);
			end
			// [R15] Three metering codes
			if (meter_ok) begin
				metering <= aar_meter_t'(wr_meter);
			end
		end
	end

	// Per-algorithm region store, one copy per selector value
	for (genvar a = 0; a < 2; a++) begin : g_region
		wire hit = wr_fire && sel_idx == 1'(a);
		// [R02] [R03] [R04] [R05] Selected region writes
		always_ff @(posedge clk) begin
			if (!rstn) begin
				region_use_enable[a] <= 1'b0;
				region_left_position[a] <= 16'h0;
				region_top_position[a] <= 16'h0;
				region_width[a] <= AAR_IMG_W_RST;
				region_height[a] <= AAR_IMG_H_RST;
			end else if (hit) begin
				if (sel_en) begin
					region_use_enable[a] <= pwdata[0];
				end
				if (sel_left) begin
					region_left_position[a] <= pwdata[15:0];
				end
				if (sel_top) begin
					region_top_position[a] <= pwdata[15:0];
				end
				if (sel_width) begin
					region_width[a] <= pwdata[15:0];
				end
				if (sel_height) begin
					region_height[a] <= pwdata[15:0];
				end
			end
		end
	end

	// Image size, balance limits, damping and target
	always_ff @(posedge clk) begin
		if (!rstn) begin
			img_width <= AAR_IMG_W_RST;
			img_height <= AAR_IMG_H_RST;
			wb_lower <= 12'h000;
			wb_upper <= AAR_RATIO_MAX;
			wb_damping <= 4'h1;
			target_grey <= AAR_TARGET_RST;
		end else if (wr_fire) begin
			if (sel_img) begin
				img_width <= pwdata[15:0];
				img_height <= pwdata[31:16];
			end
			if (sel_lower) begin
				wb_lower <= pwdata[11:0];
			end
			if (sel_upper) begin
				wb_upper <= pwdata[11:0];
			end
			if (sel_damp) begin
				wb_damping <= pwdata[3:0];
			end
			if (sel_target) begin
				target_grey <= pwdata[7:0];
			end
		end
	end

	// [R21] Measured area: region when enabled, else whole image
	// [R20] Region assumed inside the image by software
	wire [15:0] ae_x0 = region_use_enable[0] ? region_left_position[0] : 16'h0;
	wire [15:0] ae_y0 = region_use_enable[0] ? region_top_position[0] : 16'h0;
	wire [15:0] ae_w = region_use_enable[0] ? region_width[0] : img_width;
	wire [15:0] ae_h = region_use_enable[0] ? region_height[0] : img_height;

	// [R14] Metering only under normal lighting
	assign meter_live = lighting == AAR_LIGHT_NORMAL && metering != AAR_METER_AVG;
	// [R17] [R18] Centre fraction per side
	wire [5:0] frac = (metering == AAR_METER_SPOT) ? AAR_SPOT_FRAC : AAR_PART_FRAC;
	wire [21:0] cw_full = ae_w * frac;
	wire [21:0] ch_full = ae_h * frac;
	wire [15:0] cw = cw_full[21:6];
	wire [15:0] ch = ch_full[21:6];
	wire [15:0] cx = 16'(ae_x0 + ((ae_w - cw) >> 1));
	wire [15:0] cy = 16'(ae_y0 + ((ae_h - ch) >> 1));

	// [R16] Average uses the whole measured area
	assign win.x0 = meter_live ? cx : ae_x0;
	assign win.y0 = meter_live ? cy : ae_y0;
	assign win.w = meter_live ? cw : ae_w;
	assign win.h = meter_live ? ch : ae_h;

	aar_stat u_stat (
		.clk(clk),
		.rstn(rstn),
		.pix_valid(pix_valid),
		.pix_x(pix_x),
		.pix_y(pix_y),
		.pix_value(pix_value),
		.frame_end(frame_end),
		.win(win)
	);

	// [R10] Target source
	// [R12] User target value
	wire [7:0] auto_target =
		(lighting == AAR_LIGHT_BACK) ? 8'(AAR_AUTO_TARGET + AAR_COMP_SHIFT) :
		(lighting == AAR_LIGHT_FRONT) ? 8'(AAR_AUTO_TARGET - AAR_COMP_SHIFT) :
		AAR_AUTO_TARGET;
	assign target_used = target_user ? target_grey : auto_target;
	wire [39:0] goal = win.count * target_used;

	// [R11] Linear sum against target times count
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ae_too_bright <= 1'b0;
			ae_too_dark <= 1'b0;
			ae_valid <= 1'b0;
		end else begin
			ae_valid <= win.done;
			if (win.done) begin
				ae_too_bright <= win.sum > goal;
				ae_too_dark <= win.sum < goal;
			end
		end
	end

	// Balance window follows its own region or the whole image
	always_ff @(posedge clk) begin
		if (!rstn) begin
			awb_left <= 16'h0;
			awb_top <= 16'h0;
			awb_width <= AAR_IMG_W_RST;
			awb_height <= AAR_IMG_H_RST;
		end else begin
			// [R02] [R21] Balance region choice
			awb_left <= region_use_enable[1] ? region_left_position[1] : 16'h0;
			awb_top <= region_use_enable[1] ? region_top_position[1] : 16'h0;
			awb_width <= region_use_enable[1] ? region_width[1] : img_width;
			awb_height <= region_use_enable[1] ? region_height[1] : img_height;
		end
	end

	// Red and blue ratio channels
	wire [11:0] proposals [2];
	assign proposals[0] = wb_proposed_red;
	assign proposals[1] = wb_proposed_blue;
	for (genvar c = 0; c < 2; c++) begin : g_ratio
		// [R19] Outdoor profile narrows the band
		aar_wb_step u_step (
			.clk(clk),
			.rstn(rstn),
			.update(wb_update),
			.proposed(proposals[c]),
			.lower(wb_lower),
			.upper(wb_upper),
			.damping(wb_damping),
			.outdoor(wb_outdoor),
			.ratio(colour_gain_ratio[c])
		);
	end
	assign red_ratio = colour_gain_ratio[0];
	assign blue_ratio = colour_gain_ratio[1];
endmodule
`default_nettype wire

/* hw/aar_pkg.sv */
/*
 * Shared constants and types for the auto exposure / auto white balance
 * region control block: register offsets, field positions, reset values.
 * Assumes a 32-bit APB register port with 8-bit byte addresses.
 */
package aar_pkg;
	// Register byte offsets
	localparam logic [7:0] AAR_OFF_CTRL = 8'h00;
	localparam logic [7:0] AAR_OFF_REG_EN = 8'h04;
	localparam logic [7:0] AAR_OFF_REG_LEFT = 8'h08;
	localparam logic [7:0] AAR_OFF_REG_TOP = 8'h0C;
	localparam logic [7:0] AAR_OFF_REG_WIDTH = 8'h10;
	localparam logic [7:0] AAR_OFF_REG_HEIGHT = 8'h14;
	localparam logic [7:0] AAR_OFF_IMG_SIZE = 8'h18;
	localparam logic [7:0] AAR_OFF_WB_LOWER = 8'h1C;
	localparam logic [7:0] AAR_OFF_WB_UPPER = 8'h20;
	localparam logic [7:0] AAR_OFF_WB_DAMP = 8'h24;
	localparam logic [7:0] AAR_OFF_TARGET = 8'h28;
	localparam logic [7:0] AAR_OFF_STATUS = 8'h2C;
	localparam logic [7:0] AAR_OFF_RED = 8'h30;
	localparam logic [7:0] AAR_OFF_BLUE = 8'h34;
	// Control register field positions
	localparam int AAR_CTRL_ALGO = 0;
	localparam int AAR_CTRL_PROFILE = 1;
	localparam int AAR_CTRL_TMODE = 2;
	localparam int AAR_CTRL_LIGHT = 4;
	localparam int AAR_CTRL_METER = 6;
	// Widths and reset values
	localparam int AAR_COORD_W = 16;
	localparam int AAR_RATIO_W = 12;
	localparam int AAR_PIX_W = 8;
	localparam int AAR_DAMP_W = 4;
	localparam logic [11:0] AAR_RATIO_ONE = 12'h400;
	localparam logic [11:0] AAR_RATIO_MAX = 12'hFFF;
	localparam logic [11:0] AAR_OUTDOOR_MIN = 12'h300;
	localparam logic [11:0] AAR_OUTDOOR_MAX = 12'h700;
	localparam logic [15:0] AAR_IMG_W_RST = 16'h0280;
	localparam logic [15:0] AAR_IMG_H_RST = 16'h01E0;
	localparam logic [7:0] AAR_TARGET_RST = 8'h80;
	localparam logic [7:0] AAR_AUTO_TARGET = 8'h80;
	localparam logic [7:0] AAR_COMP_SHIFT = 8'h20;
	// Centre areas as fraction/64 of each side: 11/64 squared ~3%, 21/64 squared ~11%
	localparam logic [5:0] AAR_SPOT_FRAC = 6'h0B;
	localparam logic [5:0] AAR_PART_FRAC = 6'h15;
	// Modes
	typedef enum logic [1:0] {AAR_LIGHT_NORMAL = 2'h0, AAR_LIGHT_BACK = 2'h1,
		AAR_LIGHT_FRONT = 2'h2} aar_light_t;
	typedef enum logic [1:0] {AAR_METER_AVG = 2'h0, AAR_METER_SPOT = 2'h1,
		AAR_METER_PART = 2'h2} aar_meter_t;
	typedef enum logic {AAR_ALGO_AE = 1'b0, AAR_ALGO_AWB = 1'b1} aar_algo_t;
endpackage

/* hw/aar_stat.sv */
/*
 * Exposure statistics gatherer: sums linear pixel values inside a window
 * and counts them, latching both at each frame end.
 * Assumes pixels arrive on the same clock, before any gamma stage.
 */
`timescale 1ns/1ps
`default_nettype none
module aar_stat (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pixel stream
	input wire logic pix_valid,
	input wire logic [15:0] pix_x,
	input wire logic [15:0] pix_y,
	input wire logic [7:0] pix_value,
	input wire logic frame_end,
	// Window and results
	aar_win_if.stat win
);
	logic [39:0] acc;
	logic [31:0] cnt;
	wire [16:0] x_end = {1'b0, win.x0} + {1'b0, win.w};
	wire [16:0] y_end = {1'b0, win.y0} + {1'b0, win.h};
	wire in_win = pix_x >= win.x0 && {1'b0, pix_x} < x_end &&
		pix_y >= win.y0 && {1'b0, pix_y} < y_end;
	wire take = pix_valid & in_win;

	// Every pixel in the window weighs the same
	always_ff @(posedge clk) begin
		if (!rstn || frame_end) begin
			acc <= 40'h0;
			cnt <= 32'h0;
		end else if (take) begin
			acc <= acc + {32'h0, pix_value};
			cnt <= cnt + 32'h1;
		end
	end

	// Latch frame results
	always_ff @(posedge clk) begin
		if (!rstn) begin
			win.sum <= 40'h0;
			win.count <= 32'h0;
			win.done <= 1'b0;
		end else begin
			win.done <= frame_end;
			if (frame_end) begin
				win.sum <= acc;
				win.count <= cnt;
			end
		end
	end
endmodule
`default_nettype wire

/* hw/aar_wb_step.sv */
/*
 * One colour gain ratio: moves toward a proposed value by a damped step
 * and clamps the result to the programmed and profile limits.
 * Assumes the proposal comes from a white balance estimator on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
module aar_wb_step (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Proposal
	input wire logic update,
	input wire logic [11:0] proposed,
	// Limits and damping
	input wire logic [11:0] lower,
	input wire logic [11:0] upper,
	input wire logic [3:0] damping,
	input wire logic outdoor,
	// Result
	output logic [11:0] ratio
);
	import aar_pkg::*;
	wire signed [12:0] diff = $signed({1'b0, proposed}) - $signed({1'b0, ratio});
	wire signed [12:0] step = diff >>> damping;
	wire [12:0] raw = 13'({1'b0, ratio} + step);
	wire [11:0] lo = (outdoor && AAR_OUTDOOR_MIN > lower) ? AAR_OUTDOOR_MIN : lower;
	wire [11:0] hi = (outdoor && AAR_OUTDOOR_MAX < upper) ? AAR_OUTDOOR_MAX : upper;
	wire [11:0] upper_cut = (raw[11:0] > hi) ? hi : raw[11:0];
	wire [11:0] next_ratio = (upper_cut < lo) ? lo : upper_cut;

	// [R09] Damped step
	// [R07] [R08] Clamp to limits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ratio <= AAR_RATIO_ONE;
		end else if (update) begin
			ratio <= next_ratio;
		end
	end
endmodule
`default_nettype wire

/* hw/aar_win_if.sv */
/*
 * Carrier between the control core and the exposure statistics gatherer:
 * measurement window out, frame sums back.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface aar_win_if;
	logic [15:0] x0;
	logic [15:0] y0;
	logic [15:0] w;
	logic [15:0] h;
	logic [39:0] sum;
	logic [31:0] count;
	logic done;
	modport core (output x0, output y0, output w, output h,
		input sum, input count, input done);
	modport stat (input x0, input y0, input w, input h,
		output sum, output count, output done);
endinterface
`default_nettype wire

/* tb/aar_properties.sv */
/*
 * Checker for the region control block: bus timing, verdict timing,
 * ratio stability. Assumes binding onto the top module, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module aar_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Statistics and balance
	input wire logic frame_end,
	input wire logic wb_update,
	input wire logic ae_too_bright,
	input wire logic ae_too_dark,
	input wire logic ae_valid,
	input wire logic [11:0] red_ratio,
	input wire logic [11:0] blue_ratio
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// One wait state, one answer cycle
	AST_ACCESS_WAIT: assert property ($rose(psel && penable) |=> pready ##1 !pready)
		else $error("answer not one wait state");
	AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data outside answer");
	AST_RO_REFUSE: assert property (pready && pwrite && paddr inside {8'h2C, 8'h30, 8'h34} |-> pslverr)
		else $error("ratio write not refused");
	AST_UNMAPPED: assert property (pready && paddr > 8'h34 |-> pslverr)
		else $error("unmapped access not refused");
	// Verdict follows frame end by two
	AST_VERDICT_TIME: assert property (frame_end |-> ##2 ae_valid)
		else $error("verdict late");
	AST_VERDICT_CAUSE: assert property (ae_valid |-> $past(frame_end, 2))
		else $error("verdict without frame end");
	AST_VERDICT_HOLD: assert property (!ae_valid |-> $stable(ae_too_bright) && $stable(ae_too_dark))
		else $error("verdict moved between frames");
	AST_VERDICT_EXCL: assert property (!(ae_too_bright && ae_too_dark))
		else $error("both verdicts set");
	AST_RATIO_HOLD: assert property (!$past(wb_update) |-> $stable(red_ratio) && $stable(blue_ratio))
		else $error("ratio moved without update");
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for the region control block: APB tasks,
 * pixel frames and ratio proposals. Assumes the package aar_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import aar_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, pix_value = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, pix_valid = 0, frame_end = 0, wb_update = 0;
	logic [15:0] pix_x = 0, pix_y = 0, awb_left, awb_top, awb_width, awb_height;
	logic [11:0] wb_proposed_red = 0, wb_proposed_blue = 0, red_ratio, blue_ratio;
	logic ae_too_bright, ae_too_dark, ae_valid;
	int errors = 0, total_checks = 0;
	// Clock, 100 ns period
	always #50 clk = ~clk;
	aar_ctrl DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y), .pix_value(pix_value),
		.frame_end(frame_end), .wb_update(wb_update), .wb_proposed_red(wb_proposed_red),
		.wb_proposed_blue(wb_proposed_blue), .ae_too_bright(ae_too_bright),
		.ae_too_dark(ae_too_dark), .ae_valid(ae_valid), .red_ratio(red_ratio),
		.blue_ratio(blue_ratio), .awb_left(awb_left), .awb_top(awb_top),
		.awb_width(awb_width), .awb_height(awb_height));
	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, released after the answer edge
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 20);
		if (!pready) begin
			errors++;
			results();
		end
		if (!w)
			chk(prdata, ed);
		chk({31'h0, pslverr}, {31'h0, ee});
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(1, a, d, 0, 0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed);
		acc(0, a, 0, ed, 0);
	endtask
	// 64x64 frame, bright square at 20..43, then verdict
	task fr(input logic [1:0] ev);
		int n;
		for (int y = 0; y < 64; y++)
			for (int x = 0; x < 64; x++) begin
				pix_valid <= 1;
				pix_x <= 16'(x);
				pix_y <= 16'(y);
				pix_value <= (x >= 20 && x < 44 && y >= 20 && y < 44) ? 8'h90 : 8'h10;
				@(posedge clk);
			end
		pix_valid <= 0;
		frame_end <= 1;
		@(posedge clk);
		frame_end <= 0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!ae_valid && n < 8);
		if (!ae_valid) begin
			errors++;
			results();
		end
		chk({30'h0, ae_too_bright, ae_too_dark}, {30'h0, ev});
		$display("frame test done");
	endtask
	// Ratio proposal and result one cycle later
	task wb(input logic [11:0] r, input logic [11:0] b, input logic [11:0] er,
		input logic [11:0] eb);
		wb_update <= 1;
		wb_proposed_red <= r;
		wb_proposed_blue <= b;
		@(posedge clk);
		wb_update <= 0;
		@(posedge clk);
		chk({20'h0, red_ratio}, {20'h0, er});
		chk({20'h0, blue_ratio}, {20'h0, eb});
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		rd(AAR_OFF_CTRL, 0);
		rd(AAR_OFF_REG_WIDTH, 32'h280);
		rd(AAR_OFF_WB_UPPER, 32'hFFF);
		rd(AAR_OFF_WB_DAMP, 32'h1);
		rd(AAR_OFF_TARGET, 32'h80);
		chk({20'h0, red_ratio}, 32'h400);
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			wr(AAR_OFF_CTRL, (i << 6) | (i << 4) | 2);
			rd(AAR_OFF_CTRL, (i << 6) | (i << 4) | 2);
			rd(AAR_OFF_STATUS, {16'h0, i == 1 ? 8'hA0 : i == 2 ? 8'h60 : 8'h80,
				5'h0, 1'b0, 2'h0});
		end
		wr(AAR_OFF_CTRL, 32'hF0);
		rd(AAR_OFF_CTRL, 32'hA0);
		wr(AAR_OFF_TARGET, 32'h55);
		wr(AAR_OFF_CTRL, 32'h4);
		rd(AAR_OFF_STATUS, 32'h5500);
		wr(AAR_OFF_TARGET, 32'h80);
		acc(0, 8'h40, 0, 0, 1);
		acc(1, AAR_OFF_STATUS, 1, 0, 1);
		$display("mode test done");
		wr(AAR_OFF_IMG_SIZE, 32'h00400040);
		wr(AAR_OFF_REG_LEFT, 20);
		wr(AAR_OFF_REG_TOP, 20);
		wr(AAR_OFF_REG_WIDTH, 24);
		wr(AAR_OFF_REG_HEIGHT, 24);
		wr(AAR_OFF_CTRL, 32'h5);
		rd(AAR_OFF_REG_LEFT, 0);
		rd(AAR_OFF_REG_WIDTH, 32'h280);
		rd(AAR_OFF_REG_EN, 0);
		chk({awb_left, awb_width}, {16'h0, 16'h40});
		wr(AAR_OFF_REG_EN, 1);
		wr(AAR_OFF_REG_LEFT, 5);
		wr(AAR_OFF_REG_TOP, 6);
		wr(AAR_OFF_REG_WIDTH, 7);
		wr(AAR_OFF_REG_HEIGHT, 8);
		@(posedge clk);
		chk({awb_left, awb_top}, {16'd5, 16'd6});
		chk({awb_width, awb_height}, {16'd7, 16'd8});
		wr(AAR_OFF_CTRL, 32'h4);
		rd(AAR_OFF_REG_LEFT, 20);
		rd(AAR_OFF_REG_TOP, 20);
		rd(AAR_OFF_REG_HEIGHT, 24);
		chk({awb_left, awb_top}, {16'd5, 16'd6});
		wr(AAR_OFF_CTRL, 32'h5);
		wr(AAR_OFF_REG_EN, 0);
		@(posedge clk);
		chk({awb_left, awb_height}, {16'h0, 16'h40});
		wr(AAR_OFF_CTRL, 32'h4);
		$display("region test done");
		fr(2'b01);
		wr(AAR_OFF_CTRL, 32'h44);
		rd(AAR_OFF_STATUS, 32'h8006);
		fr(2'b10);
		wr(AAR_OFF_CTRL, 32'h84);
		fr(2'b10);
		wr(AAR_OFF_CTRL, 32'h54);
		fr(2'b01);
		rd(AAR_OFF_STATUS, 32'h8002);
		wr(AAR_OFF_CTRL, 32'h4);
		wr(AAR_OFF_REG_EN, 1);
		fr(2'b10);
		wr(AAR_OFF_WB_LOWER, 32'h200);
		wr(AAR_OFF_WB_UPPER, 32'h600);
		wr(AAR_OFF_WB_DAMP, 0);
		wb(12'h100, 12'hF00, 12'h200, 12'h600);
		wr(AAR_OFF_WB_DAMP, 2);
		wb(12'h600, 12'h200, 12'h300, 12'h500);
		wr(AAR_OFF_WB_LOWER, 0);
		wr(AAR_OFF_WB_UPPER, 32'hFFF);
		wr(AAR_OFF_WB_DAMP, 0);
		wr(AAR_OFF_CTRL, 32'h6);
		wb(12'h100, 12'hF00, 12'h300, 12'h700);
		rd(AAR_OFF_RED, 32'h300);
		acc(1, AAR_OFF_RED, 0, 0, 1);
		rd(AAR_OFF_BLUE, 32'h700);
		$display("balance test done");
		results();
	end
endmodule
bind aar_ctrl aar_properties u_props (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .frame_end, .wb_update, .ae_too_bright, .ae_too_dark,
	.ae_valid, .red_ratio, .blue_ratio);
`default_nettype wire
